//--- srwd_supervisor.v
// Supply reset generator and window watchdog for a step-down regulator
`timescale 1ns/1ps
`include "srwd_defines.vh"


module srwd_supervisor #(
	parameter [`SRWD_TW-1:0] REL_CYC = `SRWD_REL_CYC,
	parameter [`SRWD_TW-1:0] DIP_CYC = `SRWD_DIP_CYC,
	parameter [`SRWD_TW-1:0] FAST_POLL_CYC = `SRWD_FAST_POLL_CYC,
	parameter [`SRWD_TW-1:0] FAST_KICK_CYC = `SRWD_FAST_KICK_CYC,
	parameter [`SRWD_TW-1:0] FAST_GRACE_CYC = `SRWD_FAST_GRACE_CYC,
	parameter [`SRWD_TW-1:0] SLOW_POLL_CYC = `SRWD_SLOW_POLL_CYC,
	parameter [`SRWD_TW-1:0] SLOW_KICK_CYC = `SRWD_SLOW_KICK_CYC,
	parameter [`SRWD_TW-1:0] SLOW_GRACE_CYC = `SRWD_SLOW_GRACE_CYC
)(
	input wire mclk,
	input wire arst_n,
	// Comparator result: high while the output sits below the threshold
	input wire undervoltage_level,
	// Kick from the processor, falling edge is the trigger
	input wire kick_input,
	// High selects slow timing; the pad pull-down makes fast the default
	input wire speed_select,
	output wire supply_good_flag,
	output wire cpu_fault_flag,
	// Pull-down enables for the external open-drain drivers
	output wire supply_good_pull_en,
	output wire cpu_fault_pull_en
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire [`SRWD_NPIN-1:0] pin_raw;
wire [`SRWD_NPIN-1:0] pin_flt;

assign pin_raw = {speed_select, kick_input, undervoltage_level};

genvar gi;
generate
	for (gi = 0; gi < `SRWD_NPIN; gi = gi + 1)
	begin : g_sync
		reg s1_q;
		reg s2_q;
		reg s3_q;
		reg flt_q;
		// Three stages; a new level counts once stages two and three agree
		always @(posedge mclk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				flt_q <= 1'b0;
			end
			else
			begin
				s1_q <= pin_raw[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q)
					flt_q <= s3_q;
			end
		end
		// One driver per filtered bit, gathered into the bank
		assign pin_flt[gi] = flt_q;
	end
endgenerate

wire uv_below = pin_flt[`SRWD_PIN_UV];
wire kick_lvl = pin_flt[`SRWD_PIN_KICK];
wire spd_slow = pin_flt[`SRWD_PIN_SPD];

////////////////////////////////////////////////////////////////////////
// Reset generator

reg sg_q;
reg sg_d;
reg [`SRWD_TW-1:0] dip_q;
reg [`SRWD_TW-1:0] dip_d;
reg [`SRWD_TW-1:0] rel_q;
reg [`SRWD_TW-1:0] rel_d;

// Dip filter and release delay; the watchdog has no path into this
always @*
begin
	sg_d = sg_q;
	dip_d = dip_q;
	rel_d = rel_q;
	if (uv_below)
	begin
		rel_d = {`SRWD_TW{1'b0}};
		if (sg_q)
		begin
			// Short glitches must not reach the processor reset
			if (dip_q >= DIP_CYC - 1'b1)
			begin
				sg_d = 1'b0;
				dip_d = {`SRWD_TW{1'b0}};
			end
			else
				dip_d = dip_q + 1'b1;
		end
	end
	else
	begin
		dip_d = {`SRWD_TW{1'b0}};
		if (!sg_q)
		begin
			if (rel_q >= REL_CYC - 1'b1)
				sg_d = 1'b1;
			else
				rel_d = rel_q + 1'b1;
		end
	end
end

// Flag starts low out of reset
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		sg_q <= 1'b0;
		dip_q <= {`SRWD_TW{1'b0}};
		rel_q <= {`SRWD_TW{1'b0}};
	end
	else
	begin
		sg_q <= sg_d;
		dip_q <= dip_d;
		rel_q <= rel_d;
	end
end

////////////////////////////////////////////////////////////////////////
// Watchdog timing selection

reg spd_q;
reg spd_d;

// Window poll and kick timing use the latched speed; grace and new-window timing use the filtered pin
wire [`SRWD_TW-1:0] poll_cyc = spd_q ? SLOW_POLL_CYC : FAST_POLL_CYC;
wire [`SRWD_TW-1:0] kick_cyc = spd_q ? SLOW_KICK_CYC : FAST_KICK_CYC;
wire [`SRWD_TW-1:0] grace_cyc = spd_slow ? SLOW_GRACE_CYC : FAST_GRACE_CYC;
wire [`SRWD_TW-1:0] poll_new = spd_slow ? SLOW_POLL_CYC : FAST_POLL_CYC;
wire [`SRWD_TW-1:0] kick_new = spd_slow ? SLOW_KICK_CYC : FAST_KICK_CYC;

////////////////////////////////////////////////////////////////////////
// Watchdog state machine

reg [1:0] st_q;
reg [1:0] st_d;
reg [`SRWD_TW-1:0] tmr_q;
reg [`SRWD_TW-1:0] tmr_d;
reg [`SRWD_TW-1:0] pol_q;
reg [`SRWD_TW-1:0] pol_d;
reg [3:0] hist_q;
reg [3:0] hist_d;
reg cf_q;
reg cf_d;
reg [3:0] hist_s;

// One timer serves release, grace, window and gap phases
always @*
begin
	st_d = st_q;
	tmr_d = tmr_q;
	pol_d = pol_q;
	hist_d = hist_q;
	spd_d = spd_q;
	cf_d = cf_q;
	hist_s = {hist_q[2:0], kick_lvl};
	case (st_q)
		`SRWD_ST_FAULT:
		begin
			cf_d = 1'b0;
			if (!sg_q)
				tmr_d = REL_CYC;
			else if (tmr_q <= 1)
			begin
				// Rising cpu fault opens a fresh grace window
				st_d = `SRWD_ST_GRACE;
				cf_d = 1'b1;
				tmr_d = grace_cyc;
				spd_d = spd_slow;
			end
			else
				tmr_d = tmr_q - 1'b1;
		end
		`SRWD_ST_GRACE:
		begin
			// Kick history stays clear so nothing here counts
			hist_d = 4'h0;
			if (tmr_q <= 1)
			begin
				st_d = `SRWD_ST_WIN;
				spd_d = spd_slow;
				tmr_d = kick_new - poll_new;
				pol_d = poll_new;
			end
			else
				tmr_d = tmr_q - 1'b1;
		end
		`SRWD_ST_WIN:
		begin
			tmr_d = tmr_q - 1'b1;
			if (pol_q <= 1)
			begin
				// Sample point, one per poll interval
				pol_d = poll_cyc;
				hist_d = hist_s;
			end
			else
				pol_d = pol_q - 1'b1;
			if (pol_q <= 1 && hist_s == `SRWD_KICK_PAT)
			begin
				st_d = `SRWD_ST_GAP;
				tmr_d = poll_cyc;
			end
			else if (tmr_q <= 1)
			begin
				// Window closed empty, even if a kick was half seen
				st_d = `SRWD_ST_FAULT;
				cf_d = 1'b0;
				tmr_d = REL_CYC;
			end
		end
		`SRWD_ST_GAP:
		begin
			// Kicks landing here are lost, the history restarts
			hist_d = 4'h0;
			if (tmr_q <= 1)
			begin
				st_d = `SRWD_ST_WIN;
				spd_d = spd_slow;
				tmr_d = kick_new - poll_new;
				pol_d = poll_new;
			end
			else
				tmr_d = tmr_q - 1'b1;
		end
		default:
		begin
			st_d = `SRWD_ST_FAULT;
			cf_d = 1'b0;
			tmr_d = REL_CYC;
		end
	endcase
	// Reset state overrides the watchdog, never the other way round
	if (!sg_q)
	begin
		st_d = `SRWD_ST_FAULT;
		cf_d = 1'b0;
		tmr_d = REL_CYC;
		hist_d = 4'h0;
	end
end

// Watchdog registers
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		st_q <= `SRWD_ST_FAULT;
		tmr_q <= {`SRWD_TW{1'b0}};
		pol_q <= {`SRWD_TW{1'b0}};
		hist_q <= 4'h0;
		spd_q <= 1'b0;
		cf_q <= 1'b0;
	end
	else
	begin
		st_q <= st_d;
		tmr_q <= tmr_d;
		pol_q <= pol_d;
		hist_q <= hist_d;
		spd_q <= spd_d;
		cf_q <= cf_d;
	end
end

////////////////////////////////////////////////////////////////////////
// Outputs

reg sg_pe_q;
reg cf_pe_q;

// Pull enables from their own flops, so the pins see no gate glitches
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		sg_pe_q <= 1'b1;
		cf_pe_q <= 1'b1;
	end
	else
	begin
		sg_pe_q <= ~sg_d;
		cf_pe_q <= ~cf_d;
	end
end

// Flags and their open-drain pull-down enables
assign supply_good_flag = sg_q;
assign cpu_fault_flag = cf_q;
assign supply_good_pull_en = sg_pe_q;
assign cpu_fault_pull_en = cf_pe_q;

endmodule

//--- srwd_defines.vh
// Timing constants and encodings for the supply reset and window watchdog
`ifndef SRWD_DEFINES_VH
`define SRWD_DEFINES_VH

// Clock period of mclk in ns (50 MHz)
`define SRWD_CLK_NS 20

// Release delay, printed as 8 ms nominal
`define SRWD_REL_NS 8000000
`define SRWD_REL_CYC ((`SRWD_REL_NS + `SRWD_CLK_NS - 1) / `SRWD_CLK_NS)

// Dip filter, least time 2 us, rounded up to whole cycles
`define SRWD_DIP_NS 2000
`define SRWD_DIP_CYC ((`SRWD_DIP_NS + `SRWD_CLK_NS - 1) / `SRWD_CLK_NS)

// Watchdog timing in cycles, fast mode
`define SRWD_FAST_POLL_CYC 1000
`define SRWD_FAST_KICK_CYC 16000
`define SRWD_FAST_GRACE_CYC 64000

// Watchdog timing in cycles, slow mode
`define SRWD_SLOW_POLL_CYC 4000
`define SRWD_SLOW_KICK_CYC 64000
`define SRWD_SLOW_GRACE_CYC 256000

// Width of every timer in the block
`define SRWD_TW 24

// Watchdog states
`define SRWD_ST_FAULT 2'b00
`define SRWD_ST_GRACE 2'b01
`define SRWD_ST_WIN 2'b10
`define SRWD_ST_GAP 2'b11

// Sample history that makes a valid kick, oldest first: high high low low
`define SRWD_KICK_PAT 4'hC

// Pin indices in the synchroniser bank
`define SRWD_PIN_UV 0
`define SRWD_PIN_KICK 1
`define SRWD_PIN_SPD 2
`define SRWD_NPIN 3

`endif

//--- srwd_host.sv
// Processor model that kicks the watchdog
`timescale 1ns/1ps
module srwd_host (
	input wire mclk,
	input wire en,
	input wire [7:0] half,
	output logic kick_input
);
	logic [7:0] cnt_q;
	initial cnt_q = 8'h00;
	initial kick_input = 1'b0;
	// Square wave; a stalled cpu just freezes it
	always @(negedge mclk)
	begin
		if (!en)
			cnt_q <= 8'h00;
		else if (cnt_q + 8'h01 >= half)
		begin
			cnt_q <= 8'h00;
			kick_input <= !kick_input;
		end
		else
			cnt_q <= cnt_q + 8'h01;
	end
endmodule

//--- srwd_monitor.sv
// Checker for the supply good and cpu fault flags
`timescale 1ns/1ps
module srwd_monitor #(
	parameter int REL_CYC = 20,
	parameter int DIP_CYC = 4
)(
	input wire mclk,
	input wire arst_n,
	input wire undervoltage_level,
	input wire kick_input,
	input wire speed_select,
	input wire supply_good_flag,
	input wire cpu_fault_flag,
	input wire supply_good_pull_en,
	input wire cpu_fault_pull_en
);
	logic [15:0] abv_q, blw_q, cfl_q;
	////////////////////////////////////////
	// Run lengths; 16 bits outlast any run here
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			abv_q <= 16'h0000;
			blw_q <= 16'h0000;
			cfl_q <= 16'h0000;
		end
		else
		begin
			abv_q <= undervoltage_level ? 16'h0000 : abv_q + 16'h0001;
			blw_q <= undervoltage_level ? blw_q + 16'h0001 : 16'h0000;
			cfl_q <= cpu_fault_flag ? 16'h0000 : cfl_q + 16'h0001;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	property p_cf_follow; !supply_good_flag |=> !cpu_fault_flag; endproperty
	a_cf_follow: assert property (p_cf_follow) else $error("fault flag high with supply low");
	property p_sg_rise; $rose(supply_good_flag) |-> abv_q >= REL_CYC; endproperty
	a_sg_rise: assert property (p_sg_rise) else $error("supply good rose early");
	property p_sg_fall; $fell(supply_good_flag) |-> blw_q >= DIP_CYC; endproperty
	a_sg_fall: assert property (p_sg_fall) else $error("supply good fell on short dip");
	property p_cf_rise; $rose(cpu_fault_flag) |-> cfl_q >= REL_CYC - 1; endproperty
	a_cf_rise: assert property (p_cf_rise) else $error("fault flag low too briefly");
	property p_sg_keep; supply_good_flag && abv_q > 8 |=> supply_good_flag; endproperty
	a_sg_keep: assert property (p_sg_keep) else $error("supply good dropped");
	property p_grace; $rose(cpu_fault_flag) && abv_q > 16 |-> cpu_fault_flag [*6]; endproperty
	a_grace: assert property (p_grace) else $error("fault during grace");
	property p_pull_sg; supply_good_pull_en != supply_good_flag; endproperty
	a_pull_sg: assert property (p_pull_sg) else $error("reset pull enable wrong");
	property p_pull_cf; cpu_fault_pull_en != cpu_fault_flag; endproperty
	a_pull_cf: assert property (p_pull_cf) else $error("fault pull enable wrong");
endmodule

//--- testbench.sv
// Self-checking bench for the supply reset and window watchdog
`timescale 1ns/1ps
module testbench;
	localparam [23:0] REL = 24'h000014;
	localparam [23:0] DIP = 24'h000004;
	localparam [23:0] F_POLL = 24'h000004;
	localparam [23:0] F_KICK = 24'h000028;
	localparam [23:0] F_GRACE = 24'h00003C;
	localparam [23:0] S_POLL = 24'h000008;
	localparam [23:0] S_KICK = 24'h000050;
	localparam [23:0] S_GRACE = 24'h000064;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic uv = 1'b0;
	logic spd = 1'b0;
	logic en = 1'b0;
	logic [7:0] half = 8'h08;
	wire kick, sg, cf, sg_pe, cf_pe;
	int err_total = 0;
	int n_checks = 0;
	int n_fall = 0;
	int f0;
	always #10 mclk = ~mclk;
	always @(negedge cf) n_fall++;
	srwd_host u_host(.mclk(mclk), .en(en), .half(half), .kick_input(kick));
	srwd_supervisor #(.REL_CYC(REL), .DIP_CYC(DIP), .FAST_POLL_CYC(F_POLL), .FAST_KICK_CYC(F_KICK),
		.FAST_GRACE_CYC(F_GRACE), .SLOW_POLL_CYC(S_POLL), .SLOW_KICK_CYC(S_KICK), .SLOW_GRACE_CYC(S_GRACE))
	u_dut(.mclk(mclk), .arst_n(arst_n), .undervoltage_level(uv), .kick_input(kick), .speed_select(spd),
		.supply_good_flag(sg), .cpu_fault_flag(cf), .supply_good_pull_en(sg_pe), .cpu_fault_pull_en(cf_pe));
	////////////////////////////////////////
	task chk(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			$display("unexpected %s expected %b seen %b", nm, e, g);
			err_total++;
		end
	endtask
	// Bounded wait on cf (c=1) or sg (c=0)
	task wfor(input string nm, input bit c, input logic v, input int n);
		for (int i = 0; i < n && (c ? cf : sg) !== v; i++) @(negedge mclk);
		chk(nm, v, c ? cf : sg);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task t_power;
		repeat (REL - 1) @(negedge mclk);
		chk("sg_early", 1'b0, sg);
		wfor("sg_up", 0, 1'b1, 10);
		repeat (REL - 2) @(negedge mclk);
		chk("cf_early", 1'b0, cf);
		wfor("cf_up", 1, 1'b1, 8);
		$display("done power");
	endtask
	task t_kick;
		f0 = n_fall;
		en = 1'b1;
		repeat (600) @(negedge mclk);
		chk("fast_kept", 1'b1, n_fall == f0);
		$display("done kick");
	endtask
	// Speed changes while the fault flag is low
	task t_miss;
		en = 1'b0;
		wfor("cf_fault", 1, 1'b0, 200);
		chk("sg_kept", 1'b1, sg);
		spd = 1'b1;
		half = 8'h10;
		repeat (REL - 2) @(negedge mclk);
		chk("cf_hold", 1'b0, cf);
		wfor("cf_back", 1, 1'b1, 8);
		en = 1'b1;
		f0 = n_fall;
		repeat (1000) @(negedge mclk);
		chk("slow_kept", 1'b1, n_fall == f0);
		$display("done miss");
	endtask
	// Frozen kicks in slow mode: fault lands one grace plus one window after the rise
	task t_span;
		en = 1'b0;
		wfor("cf_lapse", 1, 1'b0, 200);
		wfor("cf_rise", 1, 1'b1, REL + 2);
		repeat (S_GRACE + S_KICK - S_POLL - 1) @(negedge mclk);
		chk("win_open", 1'b1, cf);
		@(negedge mclk);
		chk("win_end", 1'b0, cf);
		en = 1'b1;
		$display("done span");
	endtask
	task t_dip;
		uv = 1'b1;
		repeat (2) @(negedge mclk);
		uv = 1'b0;
		repeat (20) @(negedge mclk);
		chk("short_dip", 1'b1, sg);
		uv = 1'b1;
		wfor("sg_down", 0, 1'b0, 12);
		@(negedge mclk);
		chk("cf_forced", 1'b0, cf);
		chk("sg_pull", 1'b1, sg_pe);
		uv = 1'b0;
		repeat (REL - 2) @(negedge mclk);
		chk("sg_hold", 1'b0, sg);
		wfor("sg_back", 0, 1'b1, 10);
		$display("done dip");
	endtask
	initial
	begin
		repeat (5) @(negedge mclk);
		chk("sg_rst", 1'b0, sg);
		chk("cf_pull_rst", 1'b1, cf_pe);
		arst_n = 1'b1;
		t_power();
		t_kick();
		t_miss();
		t_span();
		t_dip();
		end_of_test();
	end
	// Run needs about 2000 cycles
	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule
bind srwd_supervisor srwd_monitor #(.REL_CYC(REL_CYC), .DIP_CYC(DIP_CYC)) u_mon(.mclk(mclk), .arst_n(arst_n),
	.undervoltage_level(undervoltage_level), .kick_input(kick_input), .speed_select(speed_select),
	.supply_good_flag(supply_good_flag), .cpu_fault_flag(cpu_fault_flag),
	.supply_good_pull_en(supply_good_pull_en), .cpu_fault_pull_en(cpu_fault_pull_en));
